/* File: bench/pcxcap_host_model.sv */
`default_nettype none
// ==========
// config master
module pcxcap_host_model (
  input wire logic clk,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic cfg_type0_wr,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  output logic [31:0] cfg_ad,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cfg_rd, cfg_wr, cfg_type0_wr, cfg_addr, cfg_be, cfg_wdata, cfg_ad} = '0;
  // every write is type 0; released lines flip so stale data is never read
  task automatic wr(input logic h, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d, input logic [31:0] ad);
    @(posedge clk);
    {cfg_wr, cfg_type0_wr, cfg_addr, cfg_be, cfg_wdata, cfg_ad} <= {h, 1'b1, a, b, d, ad};
    @(posedge clk);
    {cfg_wr, cfg_type0_wr, cfg_wdata, cfg_ad} <= {2'h0, ~d, ~ad};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic to);
    int n;
    n = 0;
    @(posedge clk);
    {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge clk);
    {cfg_rd, cfg_addr} <= {1'b0, ~a};
    do @(posedge clk); while (cfg_rvalid !== 1'b1 && ++n < 4);
    q = cfg_rdata;
    to = cfg_rvalid !== 1'b1;
  endtask : rd
endmodule : pcxcap_host_model
`default_nettype wire

/* File: bench/pcxcap_regs_monitor.sv */
`default_nettype none
// ==========
// port checks
module pcxcap_regs_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic cfg_type0_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_ad,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic pcix_mode,
  input wire logic nv_msi_disable,
  input wire logic evt_split_dropped,
  input wire logic master_parity_err,
  input wire logic serr_enable,
  input wire logic split_issue,
  input wire logic split_done,
  input wire logic relaxed_order_enable,
  input wire logic split_allow,
  input wire logic serr_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rd(a); cfg_rd && cfg_addr == a && !cfg_wr && !cfg_type0_wr; endsequence
  // the bench reads two edges after a write and four edges after an event, so the gap is fixed
  sequence s_cap; cfg_type0_wr ##1 !cfg_type0_wr ##1 s_rd(8'hE8); endsequence
  sequence s_drop; evt_split_dropped ##1 !cfg_wr [*3] ##1 s_rd(8'hE8); endsequence
  property p_rv; cfg_rd |=> cfg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_id; s_rd(8'hE4) |=> cfg_rdata[7:0] == 8'h07 && cfg_rdata[31:23] == 9'h0; endproperty
  a_id: assert property (p_id) else $error("bad id");
  property p_nx; s_rd(8'hE4) ##0 (!pcix_mode && nv_msi_disable) |=> cfg_rdata[15:8] == 8'h00;
  endproperty
  a_nx: assert property (p_nx) else $error("bad pointer");
  property p_cap; s_cap |=> cfg_rdata[15:0] ==
    {$past(cfg_ad[7:0], 3), $past(cfg_ad[15:11], 3), 3'h0}; endproperty
  a_cap: assert property (p_cap) else $error("bad capture");
  property p_md; !pcix_mode |=> !relaxed_order_enable; endproperty
  a_md: assert property (p_md) else $error("mode gate");
  property p_se; master_parity_err && serr_enable && !pcix_mode |=> serr_request; endproperty
  a_se: assert property (p_se) else $error("no serr");
  property p_sp; split_issue && !split_done |-> ##[1:2] !split_allow; endproperty
  a_sp: assert property (p_sp) else $error("split allowed");
  property p_dr; s_drop |=> cfg_rdata[18]; endproperty
  a_dr: assert property (p_dr) else $error("drop flag");
endmodule : pcxcap_regs_monitor
bind pcxcap_regs pcxcap_regs_monitor i_pcxcap_regs_monitor (.*);
`default_nettype wire

/* File: bench/pcxcap_regs_tb_top.sv */
`default_nettype none
// ==========
// bench top
module pcxcap_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, cfg_rd, cfg_wr, cfg_type0_wr, cfg_rvalid, to;
  logic pcix_mode, nv_msi_disable, nv_64bit, nv_133mhz, master_parity_err, serr_enable;
  logic parity_recovery_enable, relaxed_order_enable, split_allow, serr_request;
  logic [7:0] cfg_addr, req_bus_num, bus;
  logic [3:0] cfg_be, ev;
  logic [31:0] cfg_wdata, cfg_ad, cfg_rdata, q;
  logic [12:0] max_read_byte_count;
  logic [6:0] cmd;
  logic [5:0] split_limit;
  logic [4:0] req_dev_num, dev;
  logic [2:0] req_func_num;
  logic [1:0] fl;
  int n_fail, check_count, k;
  wire evt_split_dropped = ev[3];
  wire evt_split_unexpected = ev[2];
  wire split_issue = ev[1];
  wire split_done = ev[0];
  pcxcap_regs i_pcxcap_regs (.*);
  pcxcap_host_model i_pcxcap_host_model (.*);
  function automatic logic [5:0] lim(input logic [2:0] c);
    return (c < 3'h4) ? 6'(c) + 6'h01 : (c == 3'h4) ? 6'h08 : (c == 3'h5) ? 6'h0C :
      (c == 3'h6) ? 6'h10 : 6'h20;
  endfunction : lim
  function automatic logic [31:0] e4();
    return {9'h0, cmd, (!pcix_mode && nv_msi_disable) ? 8'h00 : 8'hF0, 8'h07};
  endfunction : e4
  function automatic logic [31:0] e8();
    return {9'h0, 2'h2, 1'b0, fl, nv_133mhz, nv_64bit, bus, dev, 3'h0};
  endfunction : e8
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    i_pcxcap_host_model.rd(a, q, to);
    if (to)
    begin
      n_fail++;
      tally_and_finish();
    end
    else
      chk(q, x);
  endtask : rchk
  task automatic w(input logic h, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] ad;
    ad = $urandom;
    i_pcxcap_host_model.wr(h, a, b, d, ad);
    {dev, bus} = {ad[15:11], ad[7:0]};
    if (h && b[2] && a == 8'hE4)
      cmd = d[22:16];
    if (h && b[2] && a == 8'hE8)
      fl = fl & ~d[19:18];
  endtask : w
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {rstn, pcix_mode, nv_msi_disable, master_parity_err, serr_enable, ev} = '0;
    n_fail = 0;
    check_count = 0;
    {cmd, bus, dev, fl} = {7'h02, 8'hFF, 5'h1F, 2'h0};
    k = $urandom(45342);
    {nv_64bit, nv_133mhz} = 2'($urandom);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rchk(8'hE8, e8());
    rchk(8'hE4, e4());
    repeat (40)
    begin
      @(posedge clk);
      {pcix_mode, nv_msi_disable, master_parity_err, serr_enable} <= 4'($urandom);
      k = $urandom % 3;
      w(1'($urandom), (k == 0) ? 8'hE4 : (k == 1) ? 8'hE8 : 8'hEC, 4'($urandom), $urandom);
      rchk(8'hE8, e8());
      rchk(8'hE4, e4());
      rchk(8'hEC, 32'h0);
      chk(32'({parity_recovery_enable, relaxed_order_enable, max_read_byte_count, split_limit}),
        32'(pcix_mode ? {cmd[0], cmd[1], 13'h200 << cmd[3:2], lim(cmd[6:4])} :
        {2'h0, 13'h200, 6'h01}));
      chk(32'(serr_request), 32'(master_parity_err & serr_enable & ~(pcix_mode & cmd[0])));
      chk(32'({req_bus_num, req_dev_num, req_func_num}), 32'({bus, dev, 3'h0}));
    end
    pcix_mode <= 1'b1;
    pulse(4'h8);
    fl = 2'h1;
    rchk(8'hE8, e8());
    pulse(4'h4);
    fl = 2'h3;
    rchk(8'hE8, e8());
    w(1'b1, 8'hE8, 4'hB, 32'h000C_0000);
    w(1'b1, 8'hE8, 4'hF, 32'h0);
    rchk(8'hE8, e8());
    w(1'b1, 8'hE8, 4'hF, 32'h0004_0000);
    rchk(8'hE8, e8());
    w(1'b1, 8'hE8, 4'h4, 32'h0008_0000);
    rchk(8'hE8, e8());
    pulse(4'h2);
    chk(32'(split_allow), 32'h0);
    pulse(4'h2);
    chk(32'(split_allow), 32'h0);
    pulse(4'h1);
    chk(32'(split_allow), 32'h1);
    tally_and_finish();
  end
endmodule : pcxcap_regs_tb_top
`default_nettype wire

/* File: shared/pcxcap_pkg.sv */
`default_nettype none
package pcxcap_pkg;
  // register byte offsets (dword aligned)
  localparam logic [7:0] OFS_CAP_WORD = 8'hE4;
  localparam logic [7:0] OFS_STATUS_WORD = 8'hE8;
  // fixed values
  localparam logic [7:0] CAP_ID_VAL = 8'h07;
  localparam logic [7:0] NEXT_PTR_VAL = 8'hF0;
  localparam logic [7:0] NEXT_PTR_NONE = 8'h00;
  localparam logic [2:0] FUNC_NUM_VAL = 3'h0;
  localparam logic [4:0] DEV_NUM_RST = 5'h1F;
  localparam logic [7:0] BUS_NUM_RST = 8'hFF;
  localparam logic [1:0] DESIGN_MRBC_VAL = 2'h2;
  localparam logic DEV_COMPLEX_VAL = 1'b0;
  // command word reset values
  localparam logic CMD_PARITY_RST = 1'b0;
  localparam logic CMD_RELAX_RST = 1'b1;
  localparam logic [1:0] CMD_MRBC_RST = 2'h0;
  localparam logic [2:0] CMD_SPLIT_RST = 3'h0;
  // command field positions inside dword E4
  localparam int CMD_LSB = 16;
  localparam int CMD_PARITY_BIT = 16;
  localparam int CMD_RELAX_BIT = 17;
  localparam int CMD_MRBC_LSB = 18;
  localparam int CMD_SPLIT_LSB = 20;
  // status field positions inside dword E8
  localparam int ST_DEV_LSB = 3;
  localparam int ST_BUS_LSB = 8;
  localparam int ST_DROP_BIT = 18;
  localparam int ST_UNEXP_BIT = 19;
  localparam int ST_FUNC_LSB = 0;
  localparam int ST_64B_BIT = 16;
  localparam int ST_133_BIT = 17;
  localparam int ST_CPLX_BIT = 20;
  localparam int ST_DMRBC_LSB = 21;
  // config write address bits for capture
  localparam int AD_DEV_LSB = 11;
  localparam int AD_BUS_LSB = 0;
  // capability id and pointer positions inside dword E4
  localparam int CAP_ID_LSB = 0;
  localparam int NEXT_PTR_LSB = 8;
  // byte lane that carries the low command byte and the w1c flags
  localparam int WR_LANE_BIT = 2;
  // read byte count encodings in bytes
  localparam logic [12:0] MRBC_512 = 13'h0200;
  localparam logic [12:0] MRBC_1K = 13'h0400;
  localparam logic [12:0] MRBC_2K = 13'h0800;
  localparam logic [12:0] MRBC_4K = 13'h1000;
  // split transaction limit encodings
  localparam logic [5:0] SPLIT_LIM_0 = 6'h01;
  localparam logic [5:0] SPLIT_LIM_1 = 6'h02;
  localparam logic [5:0] SPLIT_LIM_2 = 6'h03;
  localparam logic [5:0] SPLIT_LIM_3 = 6'h04;
  localparam logic [5:0] SPLIT_LIM_4 = 6'h08;
  localparam logic [5:0] SPLIT_LIM_5 = 6'h0C;
  localparam logic [5:0] SPLIT_LIM_6 = 6'h10;
  localparam logic [5:0] SPLIT_LIM_7 = 6'h20;
  localparam logic [5:0] SPLIT_HW_MAX = 6'h01;
endpackage : pcxcap_pkg
`default_nettype wire

/* File: src/pcxcap_decode.sv */
`default_nettype none
// ==========================================
// command field decode
module pcxcap_decode (
  input wire logic [1:0] mrbc_code,
  input wire logic [2:0] split_code,
  output logic [12:0] read_bytes,
  output logic [5:0] split_limit
);
  always_comb
  begin
    case (mrbc_code)
      2'h0: read_bytes = pcxcap_pkg::MRBC_512;
      2'h1: read_bytes = pcxcap_pkg::MRBC_1K;
      2'h2: read_bytes = pcxcap_pkg::MRBC_2K;
      default: read_bytes = pcxcap_pkg::MRBC_4K;
    endcase
    case (split_code)
      3'h0: split_limit = pcxcap_pkg::SPLIT_LIM_0;
      3'h1: split_limit = pcxcap_pkg::SPLIT_LIM_1;
      3'h2: split_limit = pcxcap_pkg::SPLIT_LIM_2;
      3'h3: split_limit = pcxcap_pkg::SPLIT_LIM_3;
      3'h4: split_limit = pcxcap_pkg::SPLIT_LIM_4;
      3'h5: split_limit = pcxcap_pkg::SPLIT_LIM_5;
      3'h6: split_limit = pcxcap_pkg::SPLIT_LIM_6;
      default: split_limit = pcxcap_pkg::SPLIT_LIM_7;
    endcase
  end
endmodule : pcxcap_decode
`default_nettype wire

/* File: src/pcxcap_regs.sv */
`default_nettype none
// Summary of operation
// - capability id always reads 07
// - next pointer read-only, normally F0
// - msi disabled in pci mode: pointer zero
// - visible both modes, acts only pci-x
// - parity recovery bit, else serr on parity
// - relaxed ordering bit resets one, rw
// - read byte count field rw, reset zero
// - byte count codes 512,1K,2K,4K
// - split limit field rw, eight codes
// - never more than one split outstanding
// - command bits 15:7 read zero
// - function number reads zero
// - device number captures AD[15:11]
// - bus number captures AD[7:0]
// - 64-bit flag from nonvolatile word
// - 133 MHz flag from nonvolatile word
// - dropped split completion flag, w1c
// - unexpected split completion flag, w1c
// - complexity bit reads zero
// - designed read byte count reads 2
module pcxcap_regs (
  input wire logic clk,
  input wire logic rstn,
  // configuration access, same clock domain
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic cfg_type0_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_ad,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // mode and nonvolatile straps
  input wire logic pcix_mode,
  input wire logic nv_msi_disable,
  input wire logic nv_64bit,
  input wire logic nv_133mhz,
  // events from bus logic
  input wire logic evt_split_dropped,
  input wire logic evt_split_unexpected,
  input wire logic master_parity_err,
  input wire logic serr_enable,
  input wire logic split_issue,
  input wire logic split_done,
  // settings that act on the bus logic
  output logic parity_recovery_enable,
  output logic relaxed_order_enable,
  output logic [12:0] max_read_byte_count,
  output logic [5:0] split_limit,
  output logic split_allow,
  output logic serr_request,
  output logic [7:0] req_bus_num,
  output logic [4:0] req_dev_num,
  output logic [2:0] req_func_num
);
  // ==========================================
  // state
  typedef struct packed {
    logic par_en;
    logic rlx_en;
    logic [1:0] mrbc;
    logic [2:0] split;
    logic [2:0] func;
    logic [4:0] dev;
    logic [7:0] bus;
    logic dropped;
    logic unexp;
    logic nv64;
    logic nv133;
    logic outstanding;
    logic [31:0] rdata;
    logic rvalid;
    logic o_par;
    logic o_rlx;
    logic [12:0] o_bytes;
    logic [5:0] o_lim;
    logic o_allow;
    logic o_serr;
  } pcxcap_state_t;

  pcxcap_state_t st_ff;
  pcxcap_state_t nxt_st;
  logic [12:0] dec_bytes;
  logic [5:0] dec_lim;

  pcxcap_decode u_dec (
    .mrbc_code(st_ff.mrbc),
    .split_code(st_ff.split),
    .read_bytes(dec_bytes),
    .split_limit(dec_lim)
  );

  // ==========================================
  // helper functions
  // pointer drops out of the chain when msi is hidden, pci mode only
  function automatic logic ptr_hidden(input logic pm, input logic msi_off);
    return !pm && msi_off;
  endfunction : ptr_hidden

  function automatic logic [31:0] cap_word(input pcxcap_state_t s, input logic hide);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[pcxcap_pkg::CAP_ID_LSB +: 8] = pcxcap_pkg::CAP_ID_VAL;
    if (hide)
    begin
      w[pcxcap_pkg::NEXT_PTR_LSB +: 8] = pcxcap_pkg::NEXT_PTR_NONE;
    end
    else
    begin
      w[pcxcap_pkg::NEXT_PTR_LSB +: 8] = pcxcap_pkg::NEXT_PTR_VAL;
    end
    w[pcxcap_pkg::CMD_PARITY_BIT] = s.par_en;
    w[pcxcap_pkg::CMD_RELAX_BIT] = s.rlx_en;
    w[pcxcap_pkg::CMD_MRBC_LSB +: 2] = s.mrbc;
    w[pcxcap_pkg::CMD_SPLIT_LSB +: 3] = s.split;
    // reserved command bits have no storage, so nothing can leak into them
    return w;
  endfunction : cap_word

  function automatic logic [31:0] status_word(input pcxcap_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[pcxcap_pkg::ST_FUNC_LSB +: 3] = s.func;
    w[pcxcap_pkg::ST_DEV_LSB +: 5] = s.dev;
    w[pcxcap_pkg::ST_BUS_LSB +: 8] = s.bus;
    w[pcxcap_pkg::ST_64B_BIT] = s.nv64;
    w[pcxcap_pkg::ST_133_BIT] = s.nv133;
    w[pcxcap_pkg::ST_DROP_BIT] = s.dropped;
    w[pcxcap_pkg::ST_UNEXP_BIT] = s.unexp;
    w[pcxcap_pkg::ST_CPLX_BIT] = pcxcap_pkg::DEV_COMPLEX_VAL;
    w[pcxcap_pkg::ST_DMRBC_LSB +: 2] = pcxcap_pkg::DESIGN_MRBC_VAL;
    // upper status bits belong to logic outside this block and read zero here
    return w;
  endfunction : status_word

  // ==========================================
  // read mux
  function automatic logic [31:0] rd_word(input pcxcap_state_t s, input logic [7:0] a,
                                          input logic hide);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      pcxcap_pkg::OFS_CAP_WORD: w = cap_word(s, hide);
      pcxcap_pkg::OFS_STATUS_WORD: w = status_word(s);
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : rd_word

  // ==========================================
  // write decode
  // only the lane holding the low command byte and the flags matters here
  function automatic logic lane_write(input logic wr, input logic [7:0] a, input logic [3:0] be,
                                      input logic [7:0] ofs);
    return wr && (a == ofs) && be[pcxcap_pkg::WR_LANE_BIT];
  endfunction : lane_write

  // ==========================================
  // flag and split tracking
  // an event in the same cycle as its clear wins, so no event is lost
  function automatic logic w1c_next(input logic cur, input logic evt, input logic clr);
    logic n;
    n = cur;
    if (evt)
    begin
      n = 1'b1;
    end
    else if (clr)
    begin
      n = 1'b0;
    end
    return n;
  endfunction : w1c_next

  // an issue while one split is open is ignored unless split_done comes in the same cycle; bus logic waits on split_allow
  function automatic logic split_next(input logic cur, input logic issue, input logic done);
    logic n;
    n = cur;
    if (done)
    begin
      n = 1'b0;
    end
    if (issue && !n)
    begin
      n = 1'b1;
    end
    return n;
  endfunction : split_next

  // ==========================================
  // reset values
  function automatic pcxcap_state_t reset_state(input logic s64, input logic s133);
    pcxcap_state_t r;
    r = '0;
    r.par_en = pcxcap_pkg::CMD_PARITY_RST;
    r.rlx_en = pcxcap_pkg::CMD_RELAX_RST;
    r.mrbc = pcxcap_pkg::CMD_MRBC_RST;
    r.split = pcxcap_pkg::CMD_SPLIT_RST;
    r.func = pcxcap_pkg::FUNC_NUM_VAL;
    r.dev = pcxcap_pkg::DEV_NUM_RST;
    r.bus = pcxcap_pkg::BUS_NUM_RST;
    // straps are sampled while reset is held, then frozen
    r.nv64 = s64;
    r.nv133 = s133;
    r.o_bytes = pcxcap_pkg::MRBC_512;
    r.o_lim = pcxcap_pkg::SPLIT_HW_MAX;
    r.o_allow = 1'b1;
    return r;
  endfunction : reset_state

  // ==========================================
  // next state
  always_comb
  begin
    logic wr_cmd;
    logic wr_st;
    logic hide;
    logic outst;
    wr_cmd = lane_write(cfg_wr, cfg_addr, cfg_be, pcxcap_pkg::OFS_CAP_WORD);
    wr_st = lane_write(cfg_wr, cfg_addr, cfg_be, pcxcap_pkg::OFS_STATUS_WORD);
    hide = ptr_hidden(pcix_mode, nv_msi_disable);
    outst = split_next(st_ff.outstanding, split_issue, split_done);
    nxt_st = st_ff;
    // writes land in both modes; only the outputs below are gated by mode
    if (wr_cmd)
    begin
      nxt_st.par_en = cfg_wdata[pcxcap_pkg::CMD_PARITY_BIT];
      nxt_st.rlx_en = cfg_wdata[pcxcap_pkg::CMD_RELAX_BIT];
      nxt_st.mrbc = cfg_wdata[pcxcap_pkg::CMD_MRBC_LSB +: 2];
      nxt_st.split = cfg_wdata[pcxcap_pkg::CMD_SPLIT_LSB +: 3];
    end
    // ids come from any type 0 config write, even one aimed elsewhere
    if (cfg_type0_wr)
    begin
      nxt_st.dev = cfg_ad[pcxcap_pkg::AD_DEV_LSB +: 5];
      nxt_st.bus = cfg_ad[pcxcap_pkg::AD_BUS_LSB +: 8];
    end
    // writing zero keeps a flag; read-only fields have no write path
    nxt_st.dropped = w1c_next(st_ff.dropped, evt_split_dropped,
                              wr_st && cfg_wdata[pcxcap_pkg::ST_DROP_BIT]);
    nxt_st.unexp = w1c_next(st_ff.unexp, evt_split_unexpected,
                            wr_st && cfg_wdata[pcxcap_pkg::ST_UNEXP_BIT]);
    nxt_st.func = pcxcap_pkg::FUNC_NUM_VAL;
    nxt_st.outstanding = outst;
    // read port
    nxt_st.rvalid = cfg_rd;
    if (cfg_rd)
    begin
      nxt_st.rdata = rd_word(st_ff, cfg_addr, hide);
    end
    else
    begin
      nxt_st.rdata = 32'h0000_0000;
    end
    // settings act on the bus only in pci-x mode; pci mode sees fixed defaults
    if (pcix_mode)
    begin
      nxt_st.o_par = st_ff.par_en;
      nxt_st.o_rlx = st_ff.rlx_en;
      nxt_st.o_bytes = dec_bytes;
      nxt_st.o_lim = dec_lim;
    end
    else
    begin
      nxt_st.o_par = 1'b0;
      nxt_st.o_rlx = 1'b0;
      nxt_st.o_bytes = pcxcap_pkg::MRBC_512;
      nxt_st.o_lim = pcxcap_pkg::SPLIT_HW_MAX;
    end
    // the limit is only advertised; this hold-off keeps one split open at most
    nxt_st.o_allow = !outst;
    // without recovery a master parity error is reported as a system error
    nxt_st.o_serr = master_parity_err && serr_enable && !nxt_st.o_par;
    if (!rstn)
    begin
      nxt_st = reset_state(nv_64bit, nv_133mhz);
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge clk)
  begin
    st_ff <= nxt_st;
  end

  // ==========================================
  // outputs, each straight from a register
  assign cfg_rdata = st_ff.rdata;
  assign cfg_rvalid = st_ff.rvalid;
  assign parity_recovery_enable = st_ff.o_par;
  assign relaxed_order_enable = st_ff.o_rlx;
  assign max_read_byte_count = st_ff.o_bytes;
  assign split_limit = st_ff.o_lim;
  assign split_allow = st_ff.o_allow;
  assign serr_request = st_ff.o_serr;
  assign req_bus_num = st_ff.bus;
  assign req_dev_num = st_ff.dev;
  assign req_func_num = st_ff.func;
endmodule : pcxcap_regs
`default_nettype wire
